/* File: hdl/ubbc_pkg.sv */
// shared constants for the break and baud control block
// assumes a single 250 MHz system clock
package ubbc_pkg;
    // register byte offsets on the axi4-lite slave
    localparam logic [7:0] OFS_BAUD_CTRL = 8'h00;
    localparam logic [7:0] OFS_RX_STATUS = 8'h04;
    localparam logic [7:0] OFS_RX_DATA = 8'h08;
    localparam logic [7:0] OFS_CONFIG = 8'h0c;
    localparam logic [7:0] OFS_DIVISOR = 8'h10;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h1c;
    // baud_rate_control bit positions
    localparam int BIT_AUTO_BAUD_OVERFLOW = 7;
    localparam int BIT_RECEIVER_IDLE = 6;
    localparam int BIT_IDLE_POLARITY = 4;
    localparam int BIT_WIDE_DIVIDER = 3;
    localparam int BIT_WAKE_ON_BREAK = 1;
    localparam int BIT_AUTO_BAUD_ENABLE = 0;
    // receive status bits
    localparam int BIT_RX_FLAG = 0;
    localparam int BIT_FRAMING_ERROR = 1;
    localparam int BIT_BREAK_SEEN = 2;
    // interrupt status bits
    localparam int EV_RX = 0;
    localparam int EV_BREAK = 1;
    localparam int EV_WAKE = 2;
    localparam int EV_ABD_DONE = 3;
    localparam int EV_ABD_OVF = 4;
    localparam int EV_COUNT = 5;
    // reset values, line patterns and axi response codes
    localparam logic [7:0] RST_BAUD_CTRL = 8'h40;
    localparam logic [15:0] RST_DIVISOR = 16'h00ff;
    localparam logic [7:0] SYNC_PATTERN = 8'h55;
    localparam logic [7:0] BREAK_DATA = 8'h00;
    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;
    // receiver states, gray along the main path
    typedef enum logic [2:0] {
        UBBC_IDLE = 3'b000,
        UBBC_START = 3'b001,
        UBBC_DATA = 3'b011,
        UBBC_STOP = 3'b010,
        UBBC_WAKE = 3'b110,
        UBBC_ABD = 3'b111
    } ubbc_rx_state_t;
endpackage

/* File: hdl/ubbc_sync.sv */
// two flip-flop synchroniser for a pin input
// assumes the pin is asynchronous to clk_sys
`timescale 1ns/10ps
module ubbc_sync (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // pin and synchronised level
    input wire logic pin_in,
    output logic pin_sync
);
    logic meta_reg;
    logic meta_next;
    logic sync_next;

    // next values: shift the pin through
    always_comb begin
        meta_next = pin_in;
        sync_next = meta_reg;
    end

    // register stage, line idles high
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= 1'b1;
            pin_sync <= 1'b1;
        end else begin
            meta_reg <= meta_next;
            pin_sync <= sync_next;
        end
    end
endmodule

/* File: hdl/ubbc_irq.sv */
// sticky event status, enable and write-one clear, one level interrupt
// assumes events are single-cycle pulses on clk_sys
`timescale 1ns/10ps
module ubbc_irq #(
    parameter int N = 5
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // event pulses and software controls
    input wire logic [N-1:0] event_in,
    input wire logic [N-1:0] clear_in,
    input wire logic [N-1:0] enable_in,
    // status and interrupt
    output logic [N-1:0] status,
    output logic irq
);
    logic [N-1:0] status_next;
    logic irq_next;

    // set wins over clear
    always_comb begin
        status_next = (status & ~clear_in) | event_in;
        irq_next = |(status_next & enable_in);
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            status <= '0;
            irq <= 1'b0;
        end else begin
            status <= status_next;
            irq <= irq_next;
        end
    end
endmodule

/* File: hdl/ubbc_top.sv */
// top: async receiver with break, wake and auto-baud, axi4-lite registers
// assumes rx line from a remote transmitter, software on axi4-lite
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module ubbc_top
    import ubbc_pkg::*;
#(
    parameter int ABD_W = 20
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // serial lines
    input wire logic receive_data_line,
    output logic sync_clock_line,
    output logic tx_idle_level,
    // interrupt
    output logic irq
);
    logic rx_s;
    logic rx_prev_reg;
    logic [7:0] baud_reg, baud_next;
    logic [15:0] div_reg, div_next;
    logic sync_mode_reg, sync_mode_next;
    logic [2:0] rstat_reg, rstat_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [EV_COUNT-1:0] ev_en_reg, ev_en_next, ev_clr, ev_set, ev_stat;
    ubbc_rx_state_t st_reg, st_next;
    logic [15:0] cnt_reg, cnt_next;
    logic [3:0] bit_reg, bit_next;
    logic [7:0] sh_reg, sh_next;
    logic [ABD_W-1:0] abd_reg, abd_next;
    logic aw_ok, w_ok, ar_ok;
    logic [7:0] aw_a_reg, aw_a_next, ar_a;
    logic [31:0] w_d_reg, w_d_next;
    logic awh_reg, awh_next, wh_reg, wh_next;
    logic bv_next, rv_next, sclk_next, txi_next;
    logic [31:0] rd_next;
    logic [1:0] br_next, rr_next;
    logic do_wr, rd_rx, fall, rise;
    logic [15:0] div_eff;
    logic [31:0] abd_ext;

    ubbc_sync u_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pin_in(receive_data_line),
        .pin_sync(rx_s)
    );

    ubbc_irq #(.N(EV_COUNT)) u_irq (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .event_in(ev_set),
        .clear_in(ev_clr),
        .enable_in(ev_en_reg),
        .status(ev_stat),
        .irq(irq)
    );

    // edge detect on synchronised line
    assign fall = rx_prev_reg & ~rx_s;
    assign rise = ~rx_prev_reg & rx_s;
    // divisor width select
    assign div_eff = baud_reg[BIT_WIDE_DIVIDER] ? div_reg : {8'h00, div_reg[7:0]};
    assign aw_ok = awh_reg | s_axi_awvalid;
    assign w_ok = wh_reg | s_axi_wvalid;
    assign do_wr = aw_ok & w_ok & ~s_axi_bvalid;
    assign ar_ok = s_axi_arvalid & ~s_axi_rvalid;
    assign ar_a = s_axi_araddr;
    assign rd_rx = ar_ok & (ar_a == OFS_RX_DATA);
    // measured count over eight bit times, widened before the divide
    assign abd_ext = 32'(abd_reg) >> 3;

    // axi write capture and response
    always_comb begin
        awh_next = awh_reg;
        wh_next = wh_reg;
        aw_a_next = aw_a_reg;
        w_d_next = w_d_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            awh_next = 1'b1;
            aw_a_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wh_next = 1'b1;
            w_d_next = s_axi_wdata;
        end
        if (do_wr) begin
            awh_next = 1'b0;
            wh_next = 1'b0;
        end
        bv_next = s_axi_bvalid & ~s_axi_bready;
        br_next = s_axi_bresp;
        if (do_wr) begin
            bv_next = 1'b1;
            br_next = AXI_OKAY;
            if (!(aw_a_next inside {OFS_BAUD_CTRL, OFS_CONFIG, OFS_DIVISOR,
                    OFS_IRQ_ENABLE, OFS_IRQ_CLEAR, OFS_RX_STATUS, OFS_RX_DATA,
                    OFS_IRQ_STATUS})) begin
                br_next = AXI_SLVERR;
            end
        end
    end

    // axi read path
    always_comb begin
        rv_next = s_axi_rvalid & ~s_axi_rready;
        rd_next = s_axi_rdata;
        rr_next = s_axi_rresp;
        if (ar_ok) begin
            rv_next = 1'b1;
            rr_next = AXI_OKAY;
            case (ar_a)
                OFS_BAUD_CTRL: rd_next = {24'h0, baud_reg};
                OFS_RX_STATUS: rd_next = {29'h0, rstat_reg};
                OFS_RX_DATA: rd_next = {24'h0, rdata_reg};
                OFS_CONFIG: rd_next = {31'h0, sync_mode_reg};
                OFS_DIVISOR: rd_next = {16'h0, div_reg};
                OFS_IRQ_STATUS: rd_next = {27'h0, ev_stat};
                OFS_IRQ_ENABLE: rd_next = {27'h0, ev_en_reg};
                OFS_IRQ_CLEAR: rd_next = 32'h0;
                default: begin
                    rd_next = 32'h0;
                    rr_next = AXI_SLVERR;
                end
            endcase
        end
    end

    // register writes and receiver engine
    always_comb begin
        baud_next = baud_reg;
        div_next = div_reg;
        sync_mode_next = sync_mode_reg;
        ev_en_next = ev_en_reg;
        ev_clr = '0;
        ev_set = '0;
        rstat_next = rstat_reg;
        rdata_next = rdata_reg;
        st_next = st_reg;
        cnt_next = cnt_reg;
        bit_next = bit_reg;
        sh_next = sh_reg;
        abd_next = abd_reg;
        if (do_wr) begin
            case (aw_a_next)
                OFS_BAUD_CTRL: if (s_axi_wstrb[0] | wh_reg) begin
                    baud_next[BIT_IDLE_POLARITY] = w_d_next[BIT_IDLE_POLARITY];
                    baud_next[BIT_WIDE_DIVIDER] = w_d_next[BIT_WIDE_DIVIDER];
                    baud_next[BIT_WAKE_ON_BREAK] = w_d_next[BIT_WAKE_ON_BREAK];
                    baud_next[BIT_AUTO_BAUD_ENABLE] = w_d_next[BIT_AUTO_BAUD_ENABLE];
                end
                OFS_CONFIG: sync_mode_next = w_d_next[0];
                OFS_DIVISOR: div_next = w_d_next[15:0];
                OFS_IRQ_ENABLE: ev_en_next = w_d_next[EV_COUNT-1:0];
                OFS_IRQ_CLEAR: ev_clr = w_d_next[EV_COUNT-1:0];
                default: ;
            endcase
        end
        // reading the data clears receive flag and error
        if (rd_rx) begin
            rstat_next = 3'b000;
        end
        cnt_next = cnt_reg + 16'h1;
        case (st_reg)
            UBBC_IDLE: begin
                if (!sync_mode_reg && baud_reg[BIT_WAKE_ON_BREAK] && fall) begin
                    st_next = UBBC_WAKE;
                    ev_set[EV_WAKE] = 1'b1;
                end else if (!sync_mode_reg && fall) begin
                    cnt_next = 16'h0;
                    abd_next = '0;
                    st_next = baud_reg[BIT_AUTO_BAUD_ENABLE] ? UBBC_ABD : UBBC_START;
                    bit_next = 4'd0;
                end
            end
            UBBC_WAKE: begin
                // second transition closes wake, flag raised, enable cleared
                if (rise) begin
                    baud_next[BIT_WAKE_ON_BREAK] = 1'b0;
                    rstat_next[BIT_RX_FLAG] = 1'b1;
                    ev_set[EV_RX] = 1'b1;
                    st_next = UBBC_IDLE;
                end
            end
            UBBC_ABD: begin
                // count from 1st to 5th rise of 0x55, eight bit times
                abd_next = abd_reg + {{(ABD_W-1){1'b0}}, 1'b1};
                if (&abd_reg) begin
                    baud_next[BIT_AUTO_BAUD_OVERFLOW] = 1'b1;
                    ev_set[EV_ABD_OVF] = 1'b1;
                    baud_next[BIT_AUTO_BAUD_ENABLE] = 1'b0;
                    st_next = UBBC_IDLE;
                end else if (rise) begin
                    bit_next = bit_reg + 4'd1;
                    // first rise restarts the count, start bit left out
                    if (bit_reg == 4'd0) begin
                        abd_next = {{(ABD_W-1){1'b0}}, 1'b1};
                    end
                    if (bit_reg == 4'd4) begin
                        div_next = (abd_ext[31:16] == 16'h0) ? abd_ext[15:0] : 16'hffff;
                        baud_next[BIT_AUTO_BAUD_ENABLE] = 1'b0;
                        ev_set[EV_ABD_DONE] = 1'b1;
                        st_next = UBBC_IDLE;
                    end
                end
            end
            UBBC_START: begin
                if (cnt_reg == {1'b0, div_eff[15:1]}) begin
                    cnt_next = 16'h0;
                    st_next = rx_s ? UBBC_IDLE : UBBC_DATA;
                end
            end
            UBBC_DATA: begin
                // one bit period is div_eff cycles, counted from zero
                if (cnt_reg == div_eff - 16'h1) begin
                    cnt_next = 16'h0;
                    sh_next = {rx_s, sh_reg[7:1]};
                    bit_next = bit_reg + 4'd1;
                    if (bit_reg == 4'd7) begin
                        st_next = UBBC_STOP;
                    end
                end
            end
            UBBC_STOP: begin
                if (cnt_reg == div_eff - 16'h1) begin
                    rdata_next = sh_reg;
                    rstat_next[BIT_RX_FLAG] = 1'b1;
                    rstat_next[BIT_FRAMING_ERROR] = ~rx_s;
                    rstat_next[BIT_BREAK_SEEN] = ~rx_s & (sh_reg == BREAK_DATA);
                    ev_set[EV_RX] = 1'b1;
                    ev_set[EV_BREAK] = ~rx_s & (sh_reg == BREAK_DATA);
                    st_next = UBBC_IDLE;
                end
            end
            default: st_next = UBBC_IDLE;
        endcase
        // idle flag, ignored in synchronous mode
        baud_next[BIT_RECEIVER_IDLE] = (st_next == UBBC_IDLE) | sync_mode_reg;
        sclk_next = sync_mode_reg & baud_next[BIT_IDLE_POLARITY];
        txi_next = ~baud_next[BIT_IDLE_POLARITY];
    end

    // state registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rx_prev_reg <= 1'b1;
            baud_reg <= RST_BAUD_CTRL;
            div_reg <= RST_DIVISOR;
            sync_mode_reg <= 1'b0;
            ev_en_reg <= '0;
            rstat_reg <= 3'b000;
            rdata_reg <= 8'h00;
            st_reg <= UBBC_IDLE;
            cnt_reg <= 16'h0;
            bit_reg <= 4'd0;
            sh_reg <= 8'h00;
            abd_reg <= '0;
            awh_reg <= 1'b0;
            wh_reg <= 1'b0;
            aw_a_reg <= 8'h00;
            w_d_reg <= 32'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= AXI_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= AXI_OKAY;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_arready <= 1'b1;
            sync_clock_line <= 1'b0;
            tx_idle_level <= 1'b1;
        end else begin
            rx_prev_reg <= rx_s;
            baud_reg <= baud_next;
            div_reg <= div_next;
            sync_mode_reg <= sync_mode_next;
            ev_en_reg <= ev_en_next;
            rstat_reg <= rstat_next;
            rdata_reg <= rdata_next;
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            bit_reg <= bit_next;
            sh_reg <= sh_next;
            abd_reg <= abd_next;
            awh_reg <= awh_next;
            wh_reg <= wh_next;
            aw_a_reg <= aw_a_next;
            w_d_reg <= w_d_next;
            s_axi_bvalid <= bv_next;
            s_axi_bresp <= br_next;
            s_axi_rvalid <= rv_next;
            s_axi_rdata <= rd_next;
            s_axi_rresp <= rr_next;
            // ready flops: high while nothing is held or pending
            s_axi_awready <= ~awh_next;
            s_axi_wready <= ~wh_next;
            s_axi_arready <= ~rv_next;
            sync_clock_line <= sclk_next;
            tx_idle_level <= txi_next;
        end
    end

    // checks
    sequence wake_arm_s;
        st_reg == UBBC_IDLE && !sync_mode_reg && baud_reg[BIT_WAKE_ON_BREAK] && fall;
    endsequence
    a_wake_enters: assert property (@(posedge clk_sys) disable iff (!rst_b)
        wake_arm_s |=> st_reg == UBBC_WAKE && ev_stat[EV_WAKE]) else $error("wake not entered");
    a_wake_clears: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (st_reg == UBBC_WAKE && rise) |=> !baud_reg[BIT_WAKE_ON_BREAK] && rstat_reg[0])
        else $error("wake enable not cleared");
    a_break_flag: assert property (@(posedge clk_sys) disable iff (!rst_b)
        rstat_reg[BIT_BREAK_SEEN] |-> rstat_reg[1] && rdata_reg == BREAK_DATA)
        else $error("break flag without cause");
    a_abd_done: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $fell(baud_reg[BIT_AUTO_BAUD_ENABLE]) && $past(st_reg) == UBBC_ABD
        |-> $past(ev_set[EV_ABD_DONE] | ev_set[EV_ABD_OVF])) else $error("abd clear");
    a_idle_flag: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !sync_mode_reg |-> baud_reg[BIT_RECEIVER_IDLE] == (st_reg == UBBC_IDLE))
        else $error("idle flag wrong");
    a_abd_ovf: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (st_reg == UBBC_ABD && &abd_reg) |=> baud_reg[BIT_AUTO_BAUD_OVERFLOW])
        else $error("overflow not set");
    a_ck_polarity: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ##1 sync_mode_reg && $stable(baud_reg) |=> sync_clock_line ==
        baud_reg[BIT_IDLE_POLARITY]) else $error("clock idle level wrong");
    a_div_width: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !baud_reg[BIT_WIDE_DIVIDER] |-> div_eff[15:8] == 8'h00 && div_eff[7:0] == div_reg[7:0])
        else $error("narrow divisor has high bits");
    a_rx_done: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (st_reg == UBBC_STOP && cnt_reg == div_eff - 16'h1) |=> rstat_reg[0] && ev_stat[EV_RX])
        else $error("byte completion missed");
endmodule

/* File: testbench/ubbc_line_src.sv */
// remote serial transmitter model driving the receive line
// assumes the caller enters its tasks just after a rising clk_sys edge
`timescale 1ns/10ps
module ubbc_line_src (
    // clock
    input wire logic clk_sys,
    // serial line to the receiver
    output logic line
);
    // line rests at the idle mark level
    initial line = 1'b1;

    // hold one level for n clock cycles
    task automatic level(input logic v, input int n);
        @(posedge clk_sys);
        line <= v;
        repeat (n - 1) @(posedge clk_sys);
    endtask

    // one frame lsb first; a low stop level makes a framing error
    task automatic send(input logic [7:0] d, input int per, input logic stop_lvl);
        logic [9:0] f;
        f = {stop_lvl, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            level(f[i], per);
        end
        level(1'b1, 2 * per);
    endtask
endmodule

/* File: testbench/tb_top.sv */
// self-checking bench for the break and baud control block
// assumes the line source model stands on the receive line
`timescale 1ns/10ps
`define chk(nm, exp, got) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) begin \
            miscompares++; \
            $display("[ERR] %s expected %h seen %h", nm, exp, got); \
        end \
    end
module tb_top
    import ubbc_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rd;
    logic receive_data_line, sync_clock_line, tx_idle_level, irq;
    int miscompares = 0;
    int cmp_count = 0;

    // 250 MHz system clock
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    // remote transmitter on the receive line
    ubbc_line_src src (.clk_sys(clk_sys), .line(receive_data_line));

    // block under test with a short auto-baud timer
    ubbc_top #(.ABD_W(12)) uut (
        .clk_sys(clk_sys), .rst_b(rst_b),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .receive_data_line(receive_data_line), .sync_clock_line(sync_clock_line),
        .tx_idle_level(tx_idle_level), .irq(irq)
    );

    // counts, verdict and end of run
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // a wait that ran out of cycles
    task automatic timed_out(input string what);
        miscompares++;
        $display("[ERR] %s expected answer seen none", what);
        end_of_test();
    endtask

    // axi4-lite write, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
        end while (!s_axi_bvalid && n < 200);
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
        if (!s_axi_bvalid) timed_out("write response");
    endtask

    // axi4-lite read
    task automatic rdr(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
        end while (!s_axi_rvalid && n < 200);
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        if (!s_axi_rvalid) timed_out("read data");
    endtask

    // read a register until a bit of the mask is set
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input int lim);
        int n;
        n = 0;
        do begin
            rdr(a);
            n++;
        end while ((rd & m) === 32'h0 && n < lim);
        if ((rd & m) === 32'h0) timed_out("status bit");
    endtask

    // main sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        // reset values and an unmapped place
        rdr(OFS_BAUD_CTRL);
        `chk("baud ctrl reset", 32'h1 << BIT_RECEIVER_IDLE, rd);
        rdr(OFS_DIVISOR);
        `chk("divisor reset", {16'h0, RST_DIVISOR}, rd);
        rdr(8'h24);
        `chk("unmapped resp", AXI_SLVERR, resp);
        wr(OFS_RX_DATA, 32'hff);
        `chk("read-only write resp", AXI_OKAY, resp);
        // narrow divider uses only the low byte of the divisor
        wr(OFS_DIVISOR, 32'h0110);
        wr(OFS_IRQ_ENABLE, 32'h1f);
        fork
            src.send(8'ha5, 16, 1'b1);
            begin
                repeat (40) @(posedge clk_sys);
                rdr(OFS_BAUD_CTRL);
                `chk("idle while receiving", 1'b0, rd[BIT_RECEIVER_IDLE]);
            end
        join
        poll(OFS_RX_STATUS, 32'h1, 300);
        `chk("clean frame status", 32'h1 << BIT_RX_FLAG, rd);
        rdr(OFS_RX_DATA);
        `chk("narrow divider data", 32'ha5, rd);
        rdr(OFS_RX_STATUS);
        `chk("status after data read", 32'h0, rd);
        // interrupt raised, masked and cleared
        `chk("irq raised", 1'b1, irq);
        wr(OFS_IRQ_ENABLE, 32'h0);
        repeat (2) @(posedge clk_sys);
        `chk("irq masked", 1'b0, irq);
        wr(OFS_IRQ_CLEAR, 32'h1f);
        rdr(OFS_IRQ_STATUS);
        `chk("irq cleared", 32'h0, rd);
        // wide divider with the same bit period
        wr(OFS_BAUD_CTRL, 32'h1 << BIT_WIDE_DIVIDER);
        wr(OFS_DIVISOR, 32'h0010);
        // break by framing error and zero data, then a nonzero bad frame
        src.send(BREAK_DATA, 16, 1'b0);
        poll(OFS_RX_STATUS, 32'h1, 300);
        `chk("break status", 32'h7, rd);
        rdr(OFS_IRQ_STATUS);
        `chk("break event", 32'h3, rd);
        rdr(OFS_RX_DATA);
        `chk("break data", 32'h0, rd);
        src.send(8'h80, 16, 1'b0);
        poll(OFS_RX_STATUS, 32'h1, 300);
        `chk("framing without break", 32'h3, rd);
        rdr(OFS_RX_DATA);
        wr(OFS_IRQ_CLEAR, 32'h1f);
        // wake on break, then a normal byte
        wr(OFS_BAUD_CTRL, 32'h0a);
        src.level(1'b0, 200);
        src.level(1'b1, 40);
        poll(OFS_IRQ_STATUS, 32'h1 << EV_WAKE, 300);
        rdr(OFS_BAUD_CTRL);
        `chk("wake enable cleared", 32'h48, rd);
        rdr(OFS_RX_STATUS);
        `chk("wake receive flag", 1'b1, rd[BIT_RX_FLAG]);
        rdr(OFS_RX_DATA);
        src.send(8'h3c, 16, 1'b1);
        poll(OFS_RX_STATUS, 32'h1, 300);
        rdr(OFS_RX_DATA);
        `chk("byte after wake", 32'h3c, rd);
        // auto-baud on the sync pattern, sent with no break before it
        wr(OFS_IRQ_CLEAR, 32'h1f);
        wr(OFS_BAUD_CTRL, 32'h09);
        src.send(SYNC_PATTERN, 24, 1'b1);
        poll(OFS_IRQ_STATUS, 32'h1 << EV_ABD_DONE, 300);
        rdr(OFS_BAUD_CTRL);
        `chk("auto-baud enable cleared", 32'h48, rd);
        rdr(OFS_DIVISOR);
        `chk("measured divisor", 32'd24, rd);
        rdr(OFS_RX_DATA);
        src.send(8'hc3, 24, 1'b1);
        poll(OFS_RX_STATUS, 32'h1, 300);
        rdr(OFS_RX_DATA);
        `chk("byte at measured rate", 32'hc3, rd);
        // measurement that never finishes overflows the timer
        wr(OFS_BAUD_CTRL, 32'h09);
        src.level(1'b0, 100);
        src.level(1'b1, 5000);
        poll(OFS_BAUD_CTRL, 32'h80, 100);
        `chk("overflow bit", 1'b1, rd[BIT_AUTO_BAUD_OVERFLOW]);
        rdr(OFS_IRQ_STATUS);
        `chk("overflow event", 1'b1, rd[EV_ABD_OVF]);
        // clock idle level in synchronous mode, tx idle in async
        wr(OFS_CONFIG, 32'h1);
        wr(OFS_BAUD_CTRL, 32'h18);
        repeat (2) @(posedge clk_sys);
        `chk("sync clock idle high", 1'b1, sync_clock_line);
        wr(OFS_BAUD_CTRL, 32'h08);
        repeat (2) @(posedge clk_sys);
        `chk("sync clock idle low", 1'b0, sync_clock_line);
        wr(OFS_CONFIG, 32'h0);
        wr(OFS_BAUD_CTRL, 32'h10);
        repeat (2) @(posedge clk_sys);
        `chk("tx idle low", 1'b0, tx_idle_level);
        end_of_test();
    end
endmodule
